// file: hdl/port_defines.svh
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

// Register byte offsets on the APB
`define OFF_PORT7_DIRECTION 12'h000
`define OFF_PORT7_DATA 12'h004
`define OFF_PORT_MODE_ONE 12'h008
`define OFF_PORT_MODE_FIVE 12'h00c
`define OFF_PORT2_DIRECTION 12'h010
`define OFF_PORT5_DIRECTION 12'h014
`define OFF_SERIAL_CONTROL 12'h018
`define OFF_SERIAL_MODE 12'h01c
`define OFF_PORT2_DATA 12'h020
`define OFF_PORT5_DATA 12'h024

// Field layouts
`define PORT7_IMPL_MASK 8'h77
`define PORT7_RSVD_MASK 8'h88
`define NARROW_PORT_MASK 8'h07
`define MODE_ONE_TX_SELECT_BIT 1
`define SERIAL_RX_ENABLE_BIT 4
`define SERIAL_CLOCK_ENABLE_HI_BIT 1
`define SERIAL_CLOCK_ENABLE_LO_BIT 0
`define SERIAL_MODE_SYNC_BIT 7
`define PORT2_TX_PIN 2
`define PORT2_RX_PIN 1
`define PORT2_CLOCK_PIN 0

// Reset values and read fill
`define REG8_RESET 8'h00
`define READ_FILL_ZERO 24'h000000
`define READ_EMPTY 32'h00000000

// Synchroniser width: port 7, port 2 and port 5 pins together
`define SYNC_WIDTH 14

`endif

// file: hdl/port_pkg.sv
`default_nettype none
package port_pkg;

  typedef logic [7:0] reg8_type;

  typedef enum logic [1:0] {
    clk_pin_gpio,
    clk_pin_drive,
    clk_pin_sense
  } clk_pin_role_type;

endpackage
`default_nettype wire

// file: hdl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_defines.svh"
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels in and out
  input wire logic [`SYNC_WIDTH-1:0] async_in,
  output logic [`SYNC_WIDTH-1:0] sync_out
);

  logic [`SYNC_WIDTH-1:0] meta_ff;

  generate
    for (genvar i = 0; i < `SYNC_WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_ff[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i] <= async_in[i];
          sync_out[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync
`default_nettype wire

// file: hdl/port_pin_function_select.sv
// Behaviour
// RULE1: Port 7 direction 1 drives, 0 inputs
// RULE2: Direction write-only, bits 6-4,2-0, reset 0
// RULE3: Direction bits 7 and 3 do nothing
// RULE4: Port 7 data latch drives output pins
// RULE5: Data read returns latch where output
// RULE6: Data read returns pin where input
// RULE7: Data bits 7,3 read 1; others reset 0
// RULE8: Transmit select overrides port 2 pin 2
// RULE9: Receive enable makes pin 1 receive input
// RULE10: Clock pin drives clock on 01 or synchronous
// RULE11: Upper clock enable makes pin 0 clock input
// RULE12: Wake-up select makes port 5 pin wake-up input
// RULE13: Data write updates latch whatever the direction
// RULE14: Pin levels synchronised before being read back
`timescale 1ns/100ps
`default_nettype none
`include "port_defines.svh"
module port_pin_function_select (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port 7 pins
  input wire logic [7:0] port7_pin_in,
  output logic [7:0] port7_pin_out,
  output logic [7:0] port7_pin_oe,
  // Port 2 pins
  input wire logic [2:0] port2_pin_in,
  output logic [2:0] port2_pin_out,
  output logic [2:0] port2_pin_oe,
  // Port 5 pins
  input wire logic [2:0] port5_pin_in,
  output logic [2:0] port5_pin_out,
  output logic [2:0] port5_pin_oe,
  // Serial peripheral side
  input wire logic tx_data,
  input wire logic serial_clock_drive,
  output logic rx_data,
  output logic serial_clock_sense,
  // Wake-up peripheral side
  output logic [2:0] wakeup_input
);

  // Software registers
  port_pkg::reg8_type port7_direction_ff;
  port_pkg::reg8_type port7_data_ff;
  port_pkg::reg8_type port_mode_one_ff;
  port_pkg::reg8_type port_mode_five_ff;
  port_pkg::reg8_type port2_direction_ff;
  port_pkg::reg8_type port5_direction_ff;
  port_pkg::reg8_type serial_control_ff;
  port_pkg::reg8_type serial_mode_ff;
  port_pkg::reg8_type port2_data_ff;
  port_pkg::reg8_type port5_data_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // Synchronised pin levels
  logic [`SYNC_WIDTH-1:0] pins_sync;
  wire logic [7:0] port7_sync;
  wire logic [2:0] port2_sync;
  wire logic [2:0] port5_sync;

  // Merge latch and pin per bit by direction
  function automatic port_pkg::reg8_type merge_read(
    input port_pkg::reg8_type dir,
    input port_pkg::reg8_type latch,
    input port_pkg::reg8_type pins
  );
    return (dir & latch) | (~dir & pins);
  endfunction

  pin_sync u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({port5_pin_in, port2_pin_in, port7_pin_in}),
    .sync_out(pins_sync)
  ); // [RULE14]

  assign port7_sync = pins_sync[7:0];
  assign port2_sync = pins_sync[10:8];
  assign port5_sync = pins_sync[13:11];

  // APB decode
  wire logic setup_phase = psel & ~penable;
  wire logic write_access = psel & penable & pwrite;
  wire logic hit_p7_dir = (paddr == `OFF_PORT7_DIRECTION);
  wire logic hit_p7_data = (paddr == `OFF_PORT7_DATA);
  wire logic hit_mode_one = (paddr == `OFF_PORT_MODE_ONE);
  wire logic hit_mode_five = (paddr == `OFF_PORT_MODE_FIVE);
  wire logic hit_p2_dir = (paddr == `OFF_PORT2_DIRECTION);
  wire logic hit_p5_dir = (paddr == `OFF_PORT5_DIRECTION);
  wire logic hit_ser_ctl = (paddr == `OFF_SERIAL_CONTROL);
  wire logic hit_ser_mode = (paddr == `OFF_SERIAL_MODE);
  wire logic hit_p2_data = (paddr == `OFF_PORT2_DATA);
  wire logic hit_p5_data = (paddr == `OFF_PORT5_DATA);
  wire logic addr_ok = hit_p7_dir | hit_p7_data | hit_mode_one | hit_mode_five | hit_p2_dir
                     | hit_p5_dir | hit_ser_ctl | hit_ser_mode | hit_p2_data | hit_p5_data;
  wire port_pkg::reg8_type wbyte = pwdata[7:0];

  // Next values; unmapped writes change nothing
  wire port_pkg::reg8_type nxt_port7_direction =
    (write_access & hit_p7_dir) ? (wbyte & `PORT7_IMPL_MASK) : port7_direction_ff; // [RULE2] [RULE3]
  wire port_pkg::reg8_type nxt_port7_data =
    (write_access & hit_p7_data) ? (wbyte & `PORT7_IMPL_MASK) : port7_data_ff; // [RULE13]
  wire port_pkg::reg8_type nxt_port_mode_one =
    (write_access & hit_mode_one) ? wbyte : port_mode_one_ff;
  wire port_pkg::reg8_type nxt_port_mode_five =
    (write_access & hit_mode_five) ? (wbyte & `NARROW_PORT_MASK) : port_mode_five_ff;
  wire port_pkg::reg8_type nxt_port2_direction =
    (write_access & hit_p2_dir) ? (wbyte & `NARROW_PORT_MASK) : port2_direction_ff;
  wire port_pkg::reg8_type nxt_port5_direction =
    (write_access & hit_p5_dir) ? (wbyte & `NARROW_PORT_MASK) : port5_direction_ff;
  wire port_pkg::reg8_type nxt_serial_control =
    (write_access & hit_ser_ctl) ? wbyte : serial_control_ff;
  wire port_pkg::reg8_type nxt_serial_mode =
    (write_access & hit_ser_mode) ? wbyte : serial_mode_ff;
  wire port_pkg::reg8_type nxt_port2_data =
    (write_access & hit_p2_data) ? (wbyte & `NARROW_PORT_MASK) : port2_data_ff;
  wire port_pkg::reg8_type nxt_port5_data =
    (write_access & hit_p5_data) ? (wbyte & `NARROW_PORT_MASK) : port5_data_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port7_direction_ff <= `REG8_RESET; // [RULE2]
      port7_data_ff <= `REG8_RESET; // [RULE7]
    end
    else
    begin
      port7_direction_ff <= nxt_port7_direction;
      port7_data_ff <= nxt_port7_data; // [RULE13]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_mode_one_ff <= `REG8_RESET;
      port_mode_five_ff <= `REG8_RESET;
      serial_control_ff <= `REG8_RESET;
      serial_mode_ff <= `REG8_RESET;
    end
    else
    begin
      port_mode_one_ff <= nxt_port_mode_one;
      port_mode_five_ff <= nxt_port_mode_five;
      serial_control_ff <= nxt_serial_control;
      serial_mode_ff <= nxt_serial_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port2_direction_ff <= `REG8_RESET;
      port5_direction_ff <= `REG8_RESET;
      port2_data_ff <= `REG8_RESET;
      port5_data_ff <= `REG8_RESET;
    end
    else
    begin
      port2_direction_ff <= nxt_port2_direction;
      port5_direction_ff <= nxt_port5_direction;
      port2_data_ff <= nxt_port2_data;
      port5_data_ff <= nxt_port5_data;
    end
  end

  // Read-back; direction registers are write-only and read zero
  wire port_pkg::reg8_type p7_read =
    (merge_read(port7_direction_ff, port7_data_ff, port7_sync) & `PORT7_IMPL_MASK)
    | `PORT7_RSVD_MASK; // [RULE5] [RULE6] [RULE7]
  wire port_pkg::reg8_type p2_read =
    merge_read(port2_direction_ff, port2_data_ff, {5'h00, port2_sync}) & `NARROW_PORT_MASK;
  wire port_pkg::reg8_type p5_read =
    merge_read(port5_direction_ff, port5_data_ff, {5'h00, port5_sync}) & `NARROW_PORT_MASK;
  wire port_pkg::reg8_type read_byte =
    hit_p7_data ? p7_read :
    hit_mode_one ? port_mode_one_ff :
    hit_mode_five ? port_mode_five_ff :
    hit_ser_ctl ? serial_control_ff :
    hit_ser_mode ? serial_mode_ff :
    hit_p2_data ? p2_read :
    hit_p5_data ? p5_read :
    `REG8_RESET;

  // Read data caught in setup so prdata comes from a flop with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= `READ_EMPTY;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= pwrite ? `READ_EMPTY : {`READ_FILL_ZERO, read_byte};
      pslverr_ff <= ~addr_ok;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;
  assign pready = 1'b1;

  // Port 7: plain general I/O
  assign port7_pin_oe = port7_direction_ff & `PORT7_IMPL_MASK; // [RULE1] [RULE3]
  assign port7_pin_out = port7_data_ff; // [RULE4]

  // Port 2 function selection
  wire logic tx_select = port_mode_one_ff[`MODE_ONE_TX_SELECT_BIT];
  wire logic rx_enable = serial_control_ff[`SERIAL_RX_ENABLE_BIT];
  wire logic clock_enable_hi = serial_control_ff[`SERIAL_CLOCK_ENABLE_HI_BIT];
  wire logic clock_enable_lo = serial_control_ff[`SERIAL_CLOCK_ENABLE_LO_BIT];
  wire logic sync_mode = serial_mode_ff[`SERIAL_MODE_SYNC_BIT];
  port_pkg::clk_pin_role_type clock_pin_role;

  assign clock_pin_role = clock_enable_hi ? port_pkg::clk_pin_sense : // [RULE11]
                          (clock_enable_lo | sync_mode) ? port_pkg::clk_pin_drive : // [RULE10]
                          port_pkg::clk_pin_gpio;

  logic clock_pin_oe;
  logic clock_pin_out;

  always_comb
  begin
    unique case (clock_pin_role)
      port_pkg::clk_pin_sense:
      begin
        clock_pin_oe = 1'b0;
        clock_pin_out = port2_data_ff[`PORT2_CLOCK_PIN];
      end
      port_pkg::clk_pin_drive:
      begin
        clock_pin_oe = 1'b1;
        clock_pin_out = serial_clock_drive;
      end
      port_pkg::clk_pin_gpio:
      begin
        clock_pin_oe = port2_direction_ff[`PORT2_CLOCK_PIN];
        clock_pin_out = port2_data_ff[`PORT2_CLOCK_PIN];
      end
      default:
      begin
        clock_pin_oe = 1'b0;
        clock_pin_out = 1'b0;
      end
    endcase
  end

  assign port2_pin_oe[`PORT2_TX_PIN] = tx_select | port2_direction_ff[`PORT2_TX_PIN]; // [RULE8]
  assign port2_pin_out[`PORT2_TX_PIN] = tx_select ? tx_data : port2_data_ff[`PORT2_TX_PIN]; // [RULE8]
  assign port2_pin_oe[`PORT2_RX_PIN] = ~rx_enable & port2_direction_ff[`PORT2_RX_PIN]; // [RULE9]
  assign port2_pin_out[`PORT2_RX_PIN] = port2_data_ff[`PORT2_RX_PIN];
  assign port2_pin_oe[`PORT2_CLOCK_PIN] = clock_pin_oe;
  assign port2_pin_out[`PORT2_CLOCK_PIN] = clock_pin_out;

  // Peripheral inputs gated so a disabled function sees a quiet zero
  assign rx_data = rx_enable & port2_sync[`PORT2_RX_PIN]; // [RULE9]
  assign serial_clock_sense = clock_enable_hi & port2_sync[`PORT2_CLOCK_PIN]; // [RULE11]

  // Port 5 wake-up selection
  assign port5_pin_oe = ~port_mode_five_ff[2:0] & port5_direction_ff[2:0]; // [RULE12]
  assign port5_pin_out = port5_data_ff[2:0];
  assign wakeup_input = port_mode_five_ff[2:0] & port5_sync; // [RULE12]

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup_p7_data;
    psel && !penable && !pwrite && hit_p7_data;
  endsequence

  sequence wr_p7_data;
    psel && penable && pwrite && hit_p7_data;
  endsequence

  chk_dir_write_oe: assert property ((psel && penable && pwrite && hit_p7_dir) |=> // [RULE1]
    port7_pin_oe == ($past(pwdata[7:0]) & `PORT7_IMPL_MASK))
    else $error("port 7 enable does not follow direction write");
  chk_dir_reset_state: assert property ($rose(presetn) |-> port7_pin_oe == `REG8_RESET) // [RULE2]
    else $error("port 7 pins not inputs after reset");
  chk_dir_rsvd_quiet: assert property ((port7_pin_oe & `PORT7_RSVD_MASK) == `REG8_RESET) // [RULE3]
    else $error("reserved port 7 position driven");
  chk_data_drive: assert property (wr_p7_data |=> // [RULE4]
    (port7_pin_out & `PORT7_IMPL_MASK) == ($past(pwdata[7:0]) & `PORT7_IMPL_MASK))
    else $error("port 7 output does not follow data write");
  chk_data_any_dir: assert property ((wr_p7_data and port7_direction_ff == `REG8_RESET) |=> // [RULE13]
    port7_data_ff == ($past(pwdata[7:0]) & `PORT7_IMPL_MASK))
    else $error("data latch not written while inputs");
  chk_read_latch: assert property (rd_setup_p7_data |=> // [RULE5]
    (prdata[7:0] & $past(port7_direction_ff)) == ($past(port7_data_ff) & $past(port7_direction_ff)))
    else $error("output bit read does not return latch");
  chk_read_pin: assert property (rd_setup_p7_data |=> // [RULE6]
    (prdata[7:0] & ~$past(port7_direction_ff) & `PORT7_IMPL_MASK)
    == ($past(port7_pin_in, 3) & ~$past(port7_direction_ff) & `PORT7_IMPL_MASK))
    else $error("input bit read does not return synchronised pin");
  chk_read_rsvd_one: assert property (rd_setup_p7_data |=> prdata[7] && prdata[3]) // [RULE7]
    else $error("reserved data bits not read as one");
  // Skipped for two cycles after reset: the chain restarts at zero whatever the pins show
  chk_pin_sync_delay: assert property ($past(presetn, 2) |-> port7_sync == $past(port7_pin_in, 2)) // [RULE14]
    else $error("pin level not two cycles late");
  chk_tx_override: assert property (tx_select |-> port2_pin_oe[2] && port2_pin_out[2] == tx_data) // [RULE8]
    else $error("transmit pin not driven by serial data");
  chk_rx_input: assert property (rx_enable |-> !port2_pin_oe[1] && rx_data == port2_sync[1]) // [RULE9]
    else $error("receive pin not an input");
  chk_clock_drive: assert property ((!clock_enable_hi && (clock_enable_lo || sync_mode)) |-> // [RULE10]
    port2_pin_oe[0] && port2_pin_out[0] == serial_clock_drive)
    else $error("clock pin not driving serial clock");
  chk_clock_sense: assert property (clock_enable_hi |-> // [RULE11]
    !port2_pin_oe[0] && serial_clock_sense == port2_sync[0])
    else $error("clock pin not a clock input");
  chk_wake_select: assert property ((port5_pin_oe & port_mode_five_ff[2:0]) == 3'h0) // [RULE12]
    else $error("wake-up pin driven");

endmodule // port_pin_function_select
`default_nettype wire

// file: verif/board_pins.sv
`timescale 1ns/100ps
`default_nettype none
module board_pins #(
  parameter int W = 8
) (
  // Design side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  // Board side
  input wire logic [W-1:0] board_level,
  output logic [W-1:0] pin_in
);
  // Driven pins read back their own level, the board sets the rest
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule // board_pins
`default_nettype wire

// file: verif/port_pin_function_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_defines.svh"
`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module port_pin_function_select_tb;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] pins;
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] rd;
  } row_type;
  localparam row_type ROWS [4] = '{'{8'h00, 8'hff, 8'ha5, 8'h00, 8'h77, 8'had},
    '{8'hff, 8'h5a, 8'h00, 8'h77, 8'h52, 8'hda}, '{8'h0f, 8'h33, 8'hcc, 8'h07, 8'h33, 8'hcb},
    '{8'hf0, 8'hff, 8'h0f, 8'h70, 8'h77, 8'hff}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic rerr, tx_data, serial_clock_drive, rx_data, serial_clock_sense;
  logic [7:0] port7_pin_in, port7_pin_out, port7_pin_oe, b7;
  logic [2:0] port2_pin_in, port2_pin_out, port2_pin_oe, port5_pin_in, port5_pin_out, port5_pin_oe;
  logic [2:0] b2, b5, wakeup_input;
  logic exp_oe;
  int mismatches, check_count;

  port_pin_function_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port7_pin_in(port7_pin_in), .port7_pin_out(port7_pin_out), .port7_pin_oe(port7_pin_oe),
    .port2_pin_in(port2_pin_in), .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
    .port5_pin_in(port5_pin_in), .port5_pin_out(port5_pin_out), .port5_pin_oe(port5_pin_oe),
    .tx_data(tx_data), .serial_clock_drive(serial_clock_drive), .rx_data(rx_data),
    .serial_clock_sense(serial_clock_sense), .wakeup_input(wakeup_input));
  board_pins #(.W(8)) board7 (.pin_out(port7_pin_out), .pin_oe(port7_pin_oe), .board_level(b7),
    .pin_in(port7_pin_in));
  board_pins #(.W(3)) board2 (.pin_out(port2_pin_out), .pin_oe(port2_pin_oe), .board_level(b2),
    .pin_in(port2_pin_in));
  board_pins #(.W(3)) board5 (.pin_out(port5_pin_out), .pin_oe(port5_pin_oe), .board_level(b5),
    .pin_in(port5_pin_in));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Answer taken at the same edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    logic ok;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      ok = (pready === 1'b1);
    end while (!ok && n < 50);
    rdata = prdata;
    rerr = pslverr;
    if (!ok)
    begin
      mismatches++;
      print_verdict;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    {psel, penable, pwrite, tx_data, serial_clock_drive} = '0;
    paddr = '0;
    pwdata = '0;
    {b7, b2, b5} = '0;
    mismatches = 0;
    check_count = 0;
    presetn = 1'b0;
    tick(4);
    presetn <= 1'b1;
    `CHECK("oe7 reset", 8'h00, port7_pin_oe)
    apb(0, `OFF_PORT7_DATA, 8'h00);
    `CHECK("data7 reset", 32'h00000088, rdata)
    $display("test reset done");
    foreach (ROWS[i])
    begin
      apb(1, `OFF_PORT7_DIRECTION, ROWS[i].dir);
      apb(1, `OFF_PORT7_DATA, ROWS[i].data);
      b7 <= ROWS[i].pins;
      tick(3);
      `CHECK("oe7", ROWS[i].oe, port7_pin_oe)
      `CHECK("out7", ROWS[i].out, port7_pin_out)
      apb(0, `OFF_PORT7_DATA, 8'h00);
      `CHECK("read7", {24'h000000, ROWS[i].rd}, rdata)
    end
    $display("test rows done");
    apb(0, `OFF_PORT7_DIRECTION, 8'h00);
    `CHECK("dir7 read", 32'h00000000, rdata)
    apb(1, `OFF_PORT7_DIRECTION, 8'h00);
    apb(1, `OFF_PORT7_DATA, 8'h44);
    `CHECK("oe7 off", 8'h00, port7_pin_oe)
    apb(1, `OFF_PORT7_DIRECTION, 8'h77);
    tick(1);
    `CHECK("late out7", 8'h44, port7_pin_out)
    apb(1, `OFF_PORT7_DIRECTION, 8'h00);
    b7 <= 8'h00;
    tick(4);
    b7 <= 8'h77;
    apb(0, `OFF_PORT7_DATA, 8'h00);
    `CHECK("pin early", 32'h00000088, rdata)
    apb(0, `OFF_PORT7_DATA, 8'h00);
    `CHECK("pin late", 32'h000000ff, rdata)
    $display("test port7 done");
    apb(1, `OFF_PORT_MODE_ONE, 8'h02);
    tx_data <= 1'b1;
    tick(1);
    `CHECK("tx oe", 1'b1, port2_pin_oe[2])
    `CHECK("tx hi", 1'b1, port2_pin_out[2])
    tx_data <= 1'b0;
    tick(1);
    `CHECK("tx lo", 1'b0, port2_pin_out[2])
    apb(1, `OFF_PORT_MODE_ONE, 8'h00);
    tick(1);
    `CHECK("p22 input", 1'b0, port2_pin_oe[2])
    apb(1, `OFF_PORT2_DIRECTION, 8'h07);
    apb(1, `OFF_SERIAL_CONTROL, 8'h10);
    b2 <= 3'b011;
    tick(3);
    `CHECK("rx oe", 1'b0, port2_pin_oe[1])
    `CHECK("rx data", 1'b1, rx_data)
    apb(1, `OFF_SERIAL_CONTROL, 8'h00);
    tick(1);
    `CHECK("p21 output", 1'b1, port2_pin_oe[1])
    $display("test port2 done");
    serial_clock_drive <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      apb(1, `OFF_PORT2_DIRECTION, {7'h00, i[0]});
      apb(1, `OFF_SERIAL_MODE, {i[1], 7'h00});
      apb(1, `OFF_SERIAL_CONTROL, {6'h00, i[3], i[2]});
      tick(3);
      exp_oe = i[3] ? 1'b0 : ((i[2] | i[1]) ? 1'b1 : i[0]);
      `CHECK("clk oe", exp_oe, port2_pin_oe[0])
      if (exp_oe)
        `CHECK("clk out", i[2] | i[1], port2_pin_out[0])
      `CHECK("clk sense", i[3], serial_clock_sense)
    end
    $display("test clock pin done");
    apb(1, `OFF_PORT5_DIRECTION, 8'h07);
    b5 <= 3'b111;
    for (int k = 0; k < 8; k++)
    begin
      apb(1, `OFF_PORT_MODE_FIVE, k[7:0]);
      tick(3);
      `CHECK("p5 oe", ~k[2:0], port5_pin_oe)
      `CHECK("wakeup", k[2:0], wakeup_input)
    end
    apb(1, `OFF_PORT_MODE_FIVE, 8'h00);
    apb(1, `OFF_PORT5_DATA, 8'h05);
    tick(1);
    `CHECK("p5 gpio oe", 3'b111, port5_pin_oe)
    `CHECK("p5 out", 3'b101, port5_pin_out)
    apb(0, `OFF_PORT5_DATA, 8'h00);
    `CHECK("p5 read", 32'h00000005, rdata)
    $display("test wakeup done");
    apb(1, 12'h0fc, 8'hff);
    `CHECK("bad wr err", 1'b1, rerr)
    apb(0, 12'h0fc, 8'h00);
    `CHECK("bad rd err", 1'b1, rerr)
    `CHECK("bad rd data", 32'h00000000, rdata)
    $display("test unmapped done");
    apb(1, `OFF_PORT7_DIRECTION, 8'h77);
    presetn <= 1'b0;
    tick(2);
    `CHECK("oe7 rst", 8'h00, port7_pin_oe)
    `CHECK("out7 rst", 8'h00, port7_pin_out)
    `CHECK("oe5 rst", 3'b000, port5_pin_oe)
    presetn <= 1'b1;
    tick(3);
    apb(0, `OFF_PORT7_DATA, 8'h00);
    `CHECK("read7 rst", 32'h000000ff, rdata)
    $display("test second reset done");
    print_verdict;
  end
endmodule // port_pin_function_select_tb
`default_nettype wire
